/* File: hw/csp_clock_unit.sv */
// Clock source selection, start-up delays, trim register and system clock divider.
// Assumes the source clock arrives as an enable on mclk_i and the fuses are static pins.
// Operation
// RQ1 - Codes 0100 to 0111 select the low-frequency watch crystal.
// RQ2 - Crystal mode reset delay: 14 clocks, plus 4.1 ms, plus 65 ms; 11 reserved.
// RQ3 - Crystal wake-up takes 1K clocks for 0100/0110, 32K for 0101/0111.
// RQ4 - Code 0010 selects the internal 8 MHz RC oscillator.
// RQ5 - Every reset loads the factory calibration byte into the trim register.
// RQ6 - RC wake-up takes 6 clocks; reset delay per startup code.
// RQ7 - With RC clocking, watchdog and reset time-out still use the watchdog oscillator.
// RQ8 - Seven-bit trim raises frequency monotonically, zero lowest, 0x7F highest.
// RQ9 - Software should not trim above 10% over nominal during memory writes.
// RQ10 - Code 0000 runs from external clock on the crystal input, 0 to 16 MHz.
// RQ11 - External clock wake-up takes 6 clocks; reset delay per startup code.
// RQ12 - External clock must not jump over 2% per cycle outside reset.
// RQ13 - Clock output fuse drives system clock on output pin, also during reset.
// RQ14 - With the divider active, the output pin carries the divided clock.
// RQ15 - The timer oscillator is allowed only when the RC oscillator is selected.
// RQ16 - Timer external clock select accepts an external clock on the timer pin.
// RQ17 - The divider works for every source and divides all domain clocks together.
// RQ18 - Divider register: unlock bit 7, zeros 6 to 4, select 3 to 0.
// RQ19 - The initial-divide fuse starts the device divided by eight.
// RQ20 - Select changes only after an unlock write; unlock clears after four cycles.
// RQ21 - Select codes 0 to 8 divide by 1 to 256; reset value from fuse.
// RQ22 - Fuses are sampled at reset and held static while running.
`timescale 1ns/10ps
module csp_clock_unit (
  // Clock and reset.
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  // Fuses and factory data.
  input  wire logic [3:0]  clock_source_select_fuses_i,
  input  wire logic [1:0]  startup_time_fuses_i,
  input  wire logic        initial_divide_fuse_i,
  input  wire logic        clock_output_fuse_i,
  input  wire logic [7:0]  calib_byte_i,
  // Source clock ticks and wake request.
  input  wire logic        src_tick_i,
  input  wire logic        wdt_tick_i,
  input  wire logic        wake_req_i,
  // AXI4-Lite write channels.
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read channels.
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Clock outputs.
  output logic             sys_clk_en_o,
  output logic             cpu_run_o,
  output logic             clock_output_pin_o,
  output logic             clock_output_pin_oe_n_o,
  output logic [6:0]       rc_trim_value_o,
  output logic             timer_osc_enable_o,
  output logic             timer_ext_clock_o
);

  // Whole state of the block.
  typedef struct packed {
    logic                   fuse_ok;
    logic [3:0]             src;
    logic [1:0]             startup_time_fuses;
    logic                   clock_output_fuse;
    logic [7:0]             trim;
    logic                   unlock;
    logic [2:0]             unlock_cnt;
    logic [3:0]             sel;
    logic [7:0]             div_cnt;
    logic                   clk_en;
    logic                   clk_out;
    logic                   ext_sel;
    logic                   timer_en_req;
    csp_pkg::csp_state_t    st;
    logic [15:0]            ck_cnt;
    logic [31:0]            rt_cnt;
    logic                   aw_got;
    logic                   w_got;
    logic [7:0]             aw_addr;
    logic [31:0]            w_data;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
  } csp_state_all_t;

  csp_state_all_t s_reg;
  csp_state_all_t s_next;
  logic           is_lf;
  logic           is_rc;
  logic [15:0]    wake_ck;
  logic [31:0]    rt_need;
  logic [7:0]     div_mask;

  // Decoded source type from the latched fuses.
  assign is_lf = (s_reg.src >= csp_pkg::SRC_LF_LO) && (s_reg.src <= csp_pkg::SRC_LF_HI); // RQ1
  assign is_rc = (s_reg.src == csp_pkg::SRC_RC); // RQ4

  // Wake-up length per source; odd crystal codes take the long count.
  always_comb begin
    if (is_lf) begin
      wake_ck = s_reg.src[0] ? csp_pkg::WAKE_32K_CK : csp_pkg::WAKE_1K_CK; // RQ3
    end else begin
      wake_ck = csp_pkg::WAKE_FAST_CK; // RQ6 RQ10 RQ11
    end
  end

  // Real-time reset extension, counted on watchdog ticks for every source.
  always_comb begin
    case (s_reg.startup_time_fuses)
      csp_pkg::SUT_SHORT: rt_need = 32'(csp_pkg::SHORT_CYC); // RQ2 RQ6 RQ11
      csp_pkg::SUT_LONG:  rt_need = 32'(csp_pkg::LONG_CYC);
      default:            rt_need = 32'h0000_0000;
    endcase
  end

  // Division mask: factor is two to the select code for codes up to 8; higher codes divide by one.
  always_comb begin
    div_mask = 8'h00;
    if (s_reg.sel <= csp_pkg::SEL_MAX && s_reg.sel != csp_pkg::SEL_DIV1) begin
      div_mask = 8'((9'h001 << s_reg.sel) - 9'h001); // RQ21
    end
  end

  // Next-state logic for fuses, sequencer, divider and bus slave.
  always_comb begin
    logic wr_fire;
    logic [31:0] wd;
    wr_fire = 1'b0;
    wd      = 32'h0000_0000;
    s_next  = s_reg;
    // Fuses are captured once after reset and never again.
    if (!s_reg.fuse_ok) begin
      s_next.fuse_ok = 1'b1; // RQ22
      s_next.src     = clock_source_select_fuses_i;
      s_next.startup_time_fuses     = startup_time_fuses_i;
      s_next.clock_output_fuse   = clock_output_fuse_i;
      s_next.trim    = calib_byte_i; // RQ5
      s_next.sel     = initial_divide_fuse_i ? csp_pkg::SEL_DIV8 : csp_pkg::SEL_DIV1; // RQ19
    end
    // Divider runs on every source tick whatever the source.
    s_next.clk_en = 1'b0;
    if (src_tick_i) begin
      s_next.div_cnt = (s_reg.div_cnt & div_mask) == div_mask ? 8'h00 : s_reg.div_cnt + 8'h01;
      s_next.clk_en  = ((s_reg.div_cnt & div_mask) == div_mask); // RQ17
      if ((s_reg.div_cnt & div_mask) == div_mask) begin
        s_next.clk_out = ~s_reg.clk_out; // RQ14
      end
    end
    // Start-up sequencer: source clocks, then watchdog-timed extension.
    case (s_reg.st)
      csp_pkg::CSP_ST_CK: begin
        if (s_reg.fuse_ok && src_tick_i) begin
          s_next.ck_cnt = s_reg.ck_cnt + 16'h0001;
          if (s_reg.ck_cnt + 16'h0001 >= csp_pkg::RESET_CK) begin
            s_next.ck_cnt = 16'h0000;
            s_next.st     = csp_pkg::CSP_ST_RT;
          end
        end
      end
      csp_pkg::CSP_ST_RT: begin
        if (s_reg.rt_cnt >= rt_need) begin
          s_next.st = csp_pkg::CSP_ST_RUN;
        end else if (wdt_tick_i) begin
          s_next.rt_cnt = s_reg.rt_cnt + 32'h0000_0001; // RQ7
        end
      end
      csp_pkg::CSP_ST_RUN: begin
        if (wake_req_i) begin
          s_next.ck_cnt = 16'h0000;
          s_next.st     = csp_pkg::CSP_ST_WAKE;
        end
      end
      csp_pkg::CSP_ST_WAKE: begin
        if (src_tick_i) begin
          s_next.ck_cnt = s_reg.ck_cnt + 16'h0001;
          if (s_reg.ck_cnt + 16'h0001 >= wake_ck) begin
            s_next.st = csp_pkg::CSP_ST_RUN;
          end
        end
      end
      default: s_next.st = csp_pkg::CSP_ST_CK;
    endcase
    // Unlock window closes four cycles after it opened.
    if (s_reg.unlock) begin
      s_next.unlock_cnt = s_reg.unlock_cnt + 3'h1;
      if (s_reg.unlock_cnt + 3'h1 >= csp_pkg::UNLOCK_WIN) begin
        s_next.unlock = 1'b0; // RQ20
      end
    end
    // Write address and data may come in either order.
    if (s_axi_awvalid && !s_reg.aw_got && !s_reg.bvalid) begin
      s_next.aw_got  = 1'b1;
      s_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_reg.w_got && !s_reg.bvalid) begin
      s_next.w_got  = 1'b1;
      s_next.w_data = s_axi_wdata;
    end
    if (s_reg.aw_got && s_reg.w_got) begin
      wr_fire       = 1'b1;
      wd            = s_reg.w_data;
      s_next.aw_got = 1'b0;
      s_next.w_got  = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp  = csp_pkg::RESP_OKAY;
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end
    // Register writes; only the low byte lane carries data.
    if (wr_fire) begin
      case (s_reg.aw_addr)
        csp_pkg::TRIM_OFS: s_next.trim = {1'b0, wd[6:0]}; // RQ8
        csp_pkg::DIV_OFS: begin
          if (wd[csp_pkg::UNLOCK_BIT] && wd[6:0] == 7'h00) begin
            if (!s_reg.unlock) begin
              s_next.unlock     = 1'b1; // RQ20
              s_next.unlock_cnt = 3'h0;
            end
          end else if (!wd[csp_pkg::UNLOCK_BIT] && s_reg.unlock) begin
            s_next.sel    = wd[csp_pkg::SEL_MSB:0]; // RQ18 RQ20
            s_next.unlock = 1'b0;
          end
        end
        csp_pkg::TIMER_OFS: begin
          s_next.ext_sel      = wd[1]; // RQ16
          s_next.timer_en_req = wd[0];
        end
        csp_pkg::STATUS_OFS: s_next.bresp = csp_pkg::RESP_OKAY;
        default: s_next.bresp = csp_pkg::RESP_SLVERR;
      endcase
    end
    // Reads answer one cycle after the address is taken.
    if (s_axi_arvalid && !s_reg.rvalid) begin
      s_next.rvalid = 1'b1;
      s_next.rresp  = csp_pkg::RESP_OKAY;
      case (s_axi_araddr)
        csp_pkg::TRIM_OFS:   s_next.rdata = {24'h000000, s_reg.trim};
        csp_pkg::DIV_OFS:    s_next.rdata = {24'h000000, s_reg.unlock, 3'h0, s_reg.sel}; // RQ18
        csp_pkg::TIMER_OFS:  s_next.rdata = {30'h0, s_reg.ext_sel, s_reg.timer_en_req};
        csp_pkg::STATUS_OFS: s_next.rdata = {20'h00000, s_reg.st, s_reg.startup_time_fuses, s_reg.src,
                                             s_reg.clock_output_fuse, 3'h0};
        default: begin
          s_next.rdata = 32'h0000_0000;
          s_next.rresp = csp_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
  end

  // State register; reset loads constants, calibration comes in the first cycle after.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_reg    <= '0;
      s_reg.st <= csp_pkg::CSP_ST_CK;
    end else begin
      s_reg <= s_next;
    end
  end

  // Bus handshakes and outputs.
  assign s_axi_awready = !s_reg.aw_got && !s_reg.bvalid;
  assign s_axi_wready  = !s_reg.w_got && !s_reg.bvalid;
  assign s_axi_bvalid  = s_reg.bvalid;
  assign s_axi_bresp   = s_reg.bresp;
  assign s_axi_arready = !s_reg.rvalid;
  assign s_axi_rvalid  = s_reg.rvalid;
  assign s_axi_rdata   = s_reg.rdata;
  assign s_axi_rresp   = s_reg.rresp;
  assign sys_clk_en_o  = s_reg.clk_en;
  assign cpu_run_o     = (s_reg.st == csp_pkg::CSP_ST_RUN);
  assign rc_trim_value_o = s_reg.trim[6:0];
  // The divider is held in reset, so the pin carries the raw source ticks until release.
  assign clock_output_pin_o      = rst_n_i ? s_reg.clk_out : src_tick_i; // RQ13
  // Before the fuses are latched the pin enable follows the fuse directly, so reset drives it.
  assign clock_output_pin_oe_n_o = s_reg.fuse_ok ? !s_reg.clock_output_fuse : !clock_output_fuse_i; // RQ13
  // The timer oscillator shares the crystal pins, so RC must be the source.
  assign timer_osc_enable_o = s_reg.timer_en_req && is_rc; // RQ15
  assign timer_ext_clock_o  = s_reg.ext_sel && is_rc; // RQ16

  // Checks.
  a_unlock_window: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $rose(s_reg.unlock) |-> ##[1:4] !s_reg.unlock) else $error("unlock open too long"); // RQ20
  a_sel_guard: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ($past(s_reg.fuse_ok) && !$past(s_reg.unlock)) |-> $stable(s_reg.sel))
    else $error("select changed while locked"); // RQ20
  a_timer_rc: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    timer_osc_enable_o |-> is_rc) else $error("timer osc without rc"); // RQ15
  a_fuse_static: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $past(s_reg.fuse_ok) |-> $stable(s_reg.src)) else $error("source fuse moved"); // RQ22
  a_reset_sel: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $rose(s_reg.fuse_ok) |->
      s_reg.sel == (initial_divide_fuse_i ? csp_pkg::SEL_DIV8 : csp_pkg::SEL_DIV1))
    else $error("bad reset divider"); // RQ21
  a_trim_load: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $rose(s_reg.fuse_ok) |-> s_reg.trim == $past(calib_byte_i)) else $error("no calib"); // RQ5
  a_pin_oe: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    s_reg.fuse_ok |-> (clock_output_pin_oe_n_o != clock_output_fuse_i))
    else $error("clock out enable wrong"); // RQ13
  a_div_one: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (s_reg.sel == csp_pkg::SEL_DIV1 && src_tick_i) |=> sys_clk_en_o)
    else $error("div1 missed"); // RQ17
  c_unlock: cover property (@(posedge mclk_i) $rose(s_reg.unlock));
  c_sel_change: cover property (@(posedge mclk_i) s_reg.fuse_ok && $changed(s_reg.sel));
  c_run: cover property (@(posedge mclk_i) $rose(cpu_run_o));
  c_wake: cover property (@(posedge mclk_i) s_reg.st == csp_pkg::CSP_ST_WAKE);

endmodule

/* File: hw/csp_pkg.sv */
// Package for the clock source and prescaler block: register map, fuse codes, timing.
// Assumes a 100 MHz mclk_i and 32-bit AXI4-Lite register access.
package csp_pkg;

  // Register byte offsets.
  localparam logic [7:0] TRIM_OFS   = 8'h00;
  localparam logic [7:0] DIV_OFS    = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] TIMER_OFS  = 8'h0c;

  // Divider register fields.
  localparam int unsigned UNLOCK_BIT = 7;
  localparam int unsigned SEL_MSB    = 3;
  localparam logic [3:0] SEL_DIV1    = 4'h0;
  localparam logic [3:0] SEL_DIV8    = 4'h3;
  localparam logic [3:0] SEL_MAX     = 4'h8;
  localparam logic [2:0] UNLOCK_WIN  = 3'h4;

  // Clock source select codes.
  localparam logic [3:0] SRC_EXT      = 4'h0;
  localparam logic [3:0] SRC_RC       = 4'h2;
  localparam logic [3:0] SRC_LF_LO    = 4'h4;
  localparam logic [3:0] SRC_LF_HI    = 4'h7;

  // Start-up fuse codes.
  localparam logic [1:0] SUT_NONE  = 2'h0;
  localparam logic [1:0] SUT_SHORT = 2'h1;
  localparam logic [1:0] SUT_LONG  = 2'h2;

  // Start-up delays in source clocks.
  localparam logic [15:0] RESET_CK     = 16'h000e;
  localparam logic [15:0] WAKE_FAST_CK = 16'h0006;
  localparam logic [15:0] WAKE_1K_CK   = 16'h0400;
  localparam logic [15:0] WAKE_32K_CK  = 16'h8000;

  // Real-time part of the reset delay.
  localparam real SHORT_MS = 4.1;
  localparam real LONG_MS  = 65.0;
  localparam real CLK_MHZ  = 100.0;
  // The cast rounds to nearest; a floor would lose a cycle to the binary form of 4.1.
  localparam int unsigned SHORT_CYC = int'(SHORT_MS * 1000.0 * CLK_MHZ);
  localparam int unsigned LONG_CYC  = int'(LONG_MS * 1000.0 * CLK_MHZ);

  // Nominal RC frequency in MHz and the highest trim code.
  localparam real RC_NOM_MHZ = 8.0;
  localparam logic [6:0] TRIM_MAX = 7'h7f;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Start-up sequencer states.
  typedef enum logic [1:0] {
    CSP_ST_CK    = 2'b00,
    CSP_ST_RT    = 2'b01,
    CSP_ST_RUN   = 2'b10,
    CSP_ST_WAKE  = 2'b11
  } csp_state_t;

endpackage

/* File: testbench/csp_src_model.sv */
// Source oscillator model: source-clock and watchdog-clock ticks as enables on mclk_i.
// Assumes the bench changes the tick period only while the block is held in reset.
`timescale 1ns/10ps
module csp_src_model (
  // Clock and rate.
  input  wire logic       mclk_i,
  input  wire logic [3:0] period_i,
  // Ticks.
  output logic            src_tick_o,
  output logic            wdt_tick_o
);
  logic [3:0] cnt = 4'h0;
  // A fixed rate keeps the step from one source cycle to the next at zero.
  always_ff @(posedge mclk_i) begin
    cnt <= (cnt >= period_i) ? 4'h0 : cnt + 4'h1;
  end
  // One source tick each period_i+1 cycles; the watchdog oscillator ticks every cycle.
  assign src_tick_o = (cnt == 4'h0);
  assign wdt_tick_o = 1'b1;
endmodule

/* File: testbench/clock_source_and_prescaler_tb_top.sv */
// Testbench for the clock unit: fuses, start-up, wake-up, divider unlock and registers.
// Assumes the source model ticks every cycle and start-up fuse code 00 (no real-time extension) throughout.
`timescale 1ns/10ps
module clock_source_and_prescaler_tb_top;
  logic        mclk_i = 1'b0, rst_n_i = 1'b0, initial_divide_fuse_i = 1'b1;
  logic        clock_output_fuse_i = 1'b1, wake_req_i = 1'b0;
  logic [3:0]  clock_source_select_fuses_i = 4'h2, s_axi_wstrb = 4'hf;
  logic [1:0]  startup_time_fuses_i = 2'h0, s_axi_bresp, s_axi_rresp, r;
  logic [7:0]  calib_byte_i = 8'hda, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, sys_clk_en_o, cpu_run_o;
  logic        clock_output_pin_o, clock_output_pin_oe_n_o, timer_osc_enable_o;
  logic        timer_ext_clock_o, src_tick_i, wdt_tick_i;
  logic [6:0]  rc_trim_value_o;
  int          err_total = 0, num_checks = 0, n, e, t;

  // Partner and block under test.
  csp_src_model SRC (.mclk_i, .period_i(4'h0), .src_tick_o(src_tick_i), .wdt_tick_o(wdt_tick_i));
  csp_clock_unit DUT (.mclk_i, .rst_n_i, .clock_source_select_fuses_i, .startup_time_fuses_i,
    .initial_divide_fuse_i, .clock_output_fuse_i, .calib_byte_i, .src_tick_i, .wdt_tick_i,
    .wake_req_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .sys_clk_en_o, .cpu_run_o, .clock_output_pin_o, .clock_output_pin_oe_n_o, .rc_trim_value_o,
    .timer_osc_enable_o, .timer_ext_clock_o);

  // Free-running 100 MHz clock.
  always #5 mclk_i = ~mclk_i;

  // Comparisons of design values and of counts taken by the bench.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int got, input int lo, input int hi);
    num_checks++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("MISMATCH %0t count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask

  task automatic end_of_test;
    $display("Checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Fuses change here only in reset, so the source never jumps in frequency while running.
  task automatic do_reset(input logic [3:0] src, input logic div);
    @(posedge mclk_i);
    rst_n_i <= 1'b0;
    clock_source_select_fuses_i <= src;
    initial_divide_fuse_i <= div;
    repeat (4) @(posedge mclk_i);
    chk(clock_output_pin_oe_n_o, 1'b0);
    @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
  endtask

  // Both ready signals stay high, so each answer is taken at the edge it is sampled at.
  task automatic axw(input logic [7:0] a, input logic [31:0] wd, output logic [1:0] rs);
    logic aw, w, b;
    int   k;
    k = 0;
    b = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= wd;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (b !== 1'b1 && k < 50) begin
      @(negedge mclk_i);
      aw = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge mclk_i);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      k++;
    end
    if (b !== 1'b1) chk(32'h0, 32'h1);
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] rd, output logic [1:0] rs);
    logic ar, v;
    int   k;
    k = 0;
    v = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (v !== 1'b1 && k < 50) begin
      @(negedge mclk_i);
      ar = s_axi_arvalid & s_axi_arready;
      v = s_axi_rvalid;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge mclk_i);
      if (ar) s_axi_arvalid <= 1'b0;
      k++;
    end
    if (v !== 1'b1) chk(32'h0, 32'h1);
  endtask

  // Cycles until the start-up sequencer lets the processor run.
  task automatic run_time(output int c);
    c = 0;
    while (cpu_run_o !== 1'b1 && c < 40000) begin
      @(posedge mclk_i);
      #1;
      c++;
    end
  endtask
  // Divided ticks and output pin toggles seen over a number of cycles.
  task automatic cnt_en(input int cyc, output int en, output int tg);
    logic p;
    en = 0;
    tg = 0;
    p = clock_output_pin_o;
    repeat (cyc) begin
      @(posedge mclk_i);
      #1;
      en += (sys_clk_en_o === 1'b1);
      tg += (clock_output_pin_o !== p);
      p = clock_output_pin_o;
    end
  endtask

  task automatic t_src;
    logic [3:0] codes[4] = '{4'h2, 4'h0, 4'h4, 4'h7};
    foreach (codes[i]) begin
      do_reset(codes[i], 1'b1);
      run_time(n);
      chk_rng(n, 10, 24);
      clock_source_select_fuses_i <= 4'h3;
      axr(csp_pkg::STATUS_OFS, d, r);
      chk(d[7:4], codes[i]);
      axr(csp_pkg::DIV_OFS, d, r);
      chk(d, 32'h3);
      axr(csp_pkg::TRIM_OFS, d, r);
      chk(d, 32'hda);
    end
  endtask

  task automatic t_div;
    cnt_en(64, e, t);
    chk_rng(e, 7, 9);
    chk_rng(t, 7, 9);
    axw(csp_pkg::DIV_OFS, 32'h5, r);
    axr(csp_pkg::DIV_OFS, d, r);
    chk(d, 32'h3);
    axw(csp_pkg::DIV_OFS, 32'h80, r);
    axw(csp_pkg::DIV_OFS, 32'h5, r);
    axr(csp_pkg::DIV_OFS, d, r);
    chk(d, 32'h5);
    cnt_en(64, e, t);
    chk_rng(e, 1, 3);
    axw(csp_pkg::DIV_OFS, 32'h80, r);
    repeat (6) @(posedge mclk_i);
    axw(csp_pkg::DIV_OFS, 32'h1, r);
    axr(csp_pkg::DIV_OFS, d, r);
    chk(d, 32'h5);
    axw(csp_pkg::DIV_OFS, 32'h80, r);
    axw(csp_pkg::DIV_OFS, 32'h78, r);
    axr(csp_pkg::DIV_OFS, d, r);
    chk(d, 32'h8);
    do_reset(4'h2, 1'b0);
    axr(csp_pkg::DIV_OFS, d, r);
    chk(d, 32'h0);
  endtask

  task automatic t_bus;
    // No memory write runs in this bench, so trimming to the top code is allowed here.
    axw(csp_pkg::TRIM_OFS, 32'hff, r);
    axr(csp_pkg::TRIM_OFS, d, r);
    chk(d, 32'h7f);
    chk(rc_trim_value_o, 7'h7f);
    axw(8'h10, 32'h1, r);
    chk(r, csp_pkg::RESP_SLVERR);
    axr(8'h10, d, r);
    chk(r, csp_pkg::RESP_SLVERR);
    axw(csp_pkg::TIMER_OFS, 32'h3, r);
    @(posedge mclk_i);
    chk({timer_osc_enable_o, timer_ext_clock_o}, 2'b11);
    do_reset(4'h0, 1'b0);
    axw(csp_pkg::TIMER_OFS, 32'h3, r);
    @(posedge mclk_i);
    chk(timer_osc_enable_o, 1'b0);
  endtask

  // Wake from power-down for each source, with the start-up length of that source.
  task automatic t_wake;
    logic [3:0] codes[4] = '{4'h2, 4'h0, 4'h4, 4'h5};
    int         wk[4] = '{6, 6, 1024, 32768};
    foreach (codes[i]) begin
      do_reset(codes[i], 1'b0);
      run_time(n);
      @(posedge mclk_i);
      wake_req_i <= 1'b1;
      @(posedge mclk_i);
      wake_req_i <= 1'b0;
      #1;
      chk(cpu_run_o, 1'b0);
      run_time(n);
      chk_rng(n, wk[i] - 4, wk[i] + 4);
    end
  endtask

  initial begin
    t_src;
    t_div;
    t_bus;
    t_wake;
    end_of_test;
  end

  // The longest wake-up needs about 33k cycles; the limit leaves ample room.
  initial begin
    #900000;
    err_total++;
    $display("MISMATCH %0t watchdog limit reached", $time);
    end_of_test;
  end
endmodule
